// File: hw/lcd_duty_ctl.sv
// LCD common/duty control: registers, frame clock, common drive.
// Assumes display RAM data for the current phase arrives on ram_data.
// Functional notes
// - Duty field picks static, 1/2, 1/3, 1/4; unused commons freed as ports.
// - Static with expand: all four commons carry the first common's waveform.
// - Half duty with expand: common4 copies common3, common2 copies common1.
// - Third duty with expand: common4 drives a constant non-select waveform.
// - Display bit 0 blanks segments; 1 shows display RAM contents.
// - Active bit 0 halts the controller; 1 runs it; resets to 0.
// - Power switch bit drives the resistive divider enable directly.
//
// The address map and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module lcd_duty_ctl
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // Subclock pin
   input wire logic subclk_pin,
   // Display RAM
   output logic [1:0] ram_phase,
   input wire logic [39:0] ram_data,
   // Panel drive
   output logic [3:0] common_sel,
   output logic [3:0] common_drive_en,
   output logic frame_polarity,
   output logic [39:0] seg_data,
   output logic divider_power_en,
   output logic frame_tick
);

   typedef struct packed {
      logic [7:0] port_mode;
      logic [7:0] control;
      logic [7:0] rdata;
      logic [7:0] div_cnt;
      logic [1:0] phase;
      logic pol;
      logic tick;
      logic [3:0] com_sel;
      logic [3:0] com_en;
      logic [lcd_pkg::LCD_SEG_W-1:0] seg;
   } lcd_state_t;

   lcd_state_t s_q;
   lcd_state_t s_d;
   logic sub_rise;

   // Subclock edges land three or four clocks late; only the rate matters
   lcd_pin_sync u_sub_sync
   (
      .clk(clk),
      .rst(rst),
      .pin_in(subclk_pin),
      .rise_pulse(sub_rise)
   );

   // ****************************************
   // Decode helpers
   // ****************************************
   // Number of phases minus one for the given duty
   function automatic logic [1:0] last_phase(input lcd_pkg::lcd_duty_t d);
      last_phase = d;
   endfunction

   // Commons driven for duty and expand bit
   function automatic logic [3:0] driven_mask
   (
      input lcd_pkg::lcd_duty_t d,
      input logic ex
   );
      logic [3:0] m;
      m = 4'hF;
      if (!ex)
      begin
         case (d)
            lcd_pkg::LCD_DUTY_STATIC: m = 4'h1;
            lcd_pkg::LCD_DUTY_HALF: m = 4'h3;
            lcd_pkg::LCD_DUTY_THIRD: m = 4'h7;
            default: m = 4'hF;
         endcase
      end
      driven_mask = m;
   endfunction

   // Register select, shared by the write and the read decode
   function automatic logic reg_hit
   (
      input logic [7:0] addr,
      input logic [7:0] target
   );
      reg_hit = (addr == target);
   endfunction

   lcd_pkg::lcd_duty_t duty;
   logic expand;
   logic active;
   logic [3:0] cks;
   logic src_tick;
   logic [7:0] div_lim;
   logic [3:0] base_sel;
   logic wr_mode;
   logic wr_ctl;
   logic rd_mode;
   logic rd_ctl;
   logic display_data_ctl_on;
   logic psw_on;

   // Field decode of the two stored registers
   assign duty = lcd_pkg::lcd_duty_t'(s_q.port_mode[lcd_pkg::LCD_DUTY_HI_BIT:
                                      lcd_pkg::LCD_DUTY_LO_BIT]);
   assign expand = s_q.port_mode[lcd_pkg::LCD_EXPAND_BIT];
   assign active = s_q.control[lcd_pkg::LCD_ACT_BIT];
   assign cks = s_q.control[lcd_pkg::LCD_FRAME_CLK_SEL3_BIT:0];
   assign display_data_ctl_on = s_q.control[lcd_pkg::LCD_DISPLAY_DATA_CTL_BIT];
   assign psw_on = s_q.control[lcd_pkg::LCD_PSW_BIT];

   // ****************************************
   // Register decode
   // ****************************************
   // Unmapped addresses match nothing: writes vanish and reads give zero
   assign wr_mode = reg_wr && reg_hit(reg_addr, lcd_pkg::LCD_PORT_MODE_ADDR);
   assign wr_ctl = reg_wr && reg_hit(reg_addr, lcd_pkg::LCD_CONTROL_ADDR);
   assign rd_mode = reg_rd && reg_hit(reg_addr, lcd_pkg::LCD_PORT_MODE_ADDR);
   assign rd_ctl = reg_rd && reg_hit(reg_addr, lcd_pkg::LCD_CONTROL_ADDR);

   // ****************************************
   // Frame clock source and divider
   // ****************************************
   always_comb
   begin
      // One counter serves both sources, so a selector change mid-count
      // can stretch or cut short the phase in progress
      if (cks[3])
      begin
         src_tick = 1'b1;
         div_lim = 8'((9'h002 << cks[2:0]) - 9'h001);
      end
      else
      begin
         src_tick = sub_rise;
         case (cks[1:0])
            2'b00: div_lim = lcd_pkg::LCD_SUB_LIM_0;
            2'b01: div_lim = lcd_pkg::LCD_SUB_LIM_1;
            default: div_lim = lcd_pkg::LCD_SUB_LIM_2;
         endcase
      end
   end

   // Selection pattern of the current phase before masking to the driven commons
   always_comb
   begin
      base_sel = 4'h1 << s_q.phase;
      case (duty)
         lcd_pkg::LCD_DUTY_STATIC:
         begin
            if (expand)
            begin
               base_sel = 4'hF;
            end
            else
            begin
               base_sel = 4'h1;
            end
         end
         lcd_pkg::LCD_DUTY_HALF:
         begin
            if (expand)
            begin
               // Commons 1 and 2 select in phase 0, commons 3 and 4 in 1
               base_sel = s_q.phase[0] ? 4'hC : 4'h3;
            end
         end
         lcd_pkg::LCD_DUTY_THIRD:
         begin
            // Common 4 is never selected; it stays driven only with expand
            base_sel[3] = 1'b0;
         end
         default:
         begin
            base_sel = 4'h1 << s_q.phase;
         end
      endcase
   end

   // ****************************************
   // Next state
   // ****************************************
   always_comb
   begin
      s_d = s_q;
      s_d.tick = 1'b0;
      // Read data lasts one cycle, then falls back to zero
      s_d.rdata = lcd_pkg::LCD_UNMAPPED_READ;

      if (wr_mode)
      begin
         s_d.port_mode = reg_wdata;
      end
      if (wr_ctl)
      begin
         // Top bit is unused and always reads one
         s_d.control = {1'b1, reg_wdata[6:0]};
      end
      if (rd_mode)
      begin
         s_d.rdata = s_q.port_mode;
      end
      if (rd_ctl)
      begin
         s_d.rdata = s_q.control;
      end

      if (!active)
      begin
         // Stopped: counters held at start, panel lines idle
         // Starting again always opens at phase 0 with polarity low
         s_d.div_cnt = 8'h00;
         s_d.phase = 2'b00;
         s_d.pol = 1'b0;
         s_d.com_sel = 4'h0;
         s_d.com_en = 4'h0;
         s_d.seg = '0;
      end
      else
      begin
         if (src_tick)
         begin
            if (s_q.div_cnt >= div_lim)
            begin
               s_d.div_cnt = 8'h00;
               s_d.tick = 1'b1;
               if (s_q.phase >= last_phase(duty))
               begin
                  s_d.phase = 2'b00;
                  // Polarity flips each frame so the panel sees no DC
                  s_d.pol = !s_q.pol;
               end
               else
               begin
                  s_d.phase = s_q.phase + 2'b01;
               end
            end
            else
            begin
               s_d.div_cnt = s_q.div_cnt + 8'h01;
            end
         end
         s_d.com_en = driven_mask(duty, expand);
         s_d.com_sel = base_sel & driven_mask(duty, expand);
         // Blanking still scans the commons, keeping the panel AC-driven
         if (display_data_ctl_on)
         begin
            s_d.seg = ram_data;
         end
         else
         begin
            s_d.seg = '0;
         end
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         s_q <= '0;
         s_q.port_mode <= lcd_pkg::LCD_PORT_MODE_RST;
         s_q.control <= lcd_pkg::LCD_CONTROL_RST;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   // Enables and selects leave straight from flip-flops, so pins never glitch
   genvar gi;
   generate
      for (gi = 0; gi < lcd_pkg::LCD_NUM_COM; gi = gi + 1)
      begin : g_com
         assign common_sel[gi] = s_q.com_sel[gi];
         assign common_drive_en[gi] = s_q.com_en[gi];
      end
   endgenerate

   assign reg_rdata = s_q.rdata;
   assign ram_phase = s_q.phase;
   assign frame_polarity = s_q.pol;
   assign seg_data = s_q.seg;
   assign frame_tick = s_q.tick;
   assign divider_power_en = psw_on;

endmodule // lcd_duty_ctl
`default_nettype wire

// File: hw/lcd_pkg.sv
// Constants for the LCD common/duty control block.
// Assumes one 50 MHz system clock and an asynchronous subclock pin.
package lcd_pkg;

   // ****************************************
   // Register map
   // ****************************************
   localparam logic [7:0] LCD_PORT_MODE_ADDR = 8'h00;
   localparam logic [7:0] LCD_CONTROL_ADDR = 8'h01;
   localparam logic [7:0] LCD_PORT_MODE_RST = 8'h00;
   localparam logic [7:0] LCD_CONTROL_RST = 8'h80;
   localparam logic [7:0] LCD_UNMAPPED_READ = 8'h00;

   // ****************************************
   // Field positions
   // ****************************************
   localparam int LCD_DUTY_HI_BIT = 7;
   localparam int LCD_DUTY_LO_BIT = 6;
   localparam int LCD_EXPAND_BIT = 5;
   localparam int LCD_PSW_BIT = 6;
   localparam int LCD_ACT_BIT = 5;
   localparam int LCD_DISPLAY_DATA_CTL_BIT = 4;
   localparam int LCD_FRAME_CLK_SEL3_BIT = 3;

   // ****************************************
   // Sizes and divider limits
   // ****************************************
   localparam int LCD_NUM_COM = 4;
   localparam int LCD_SEG_W = 40;
   localparam logic [7:0] LCD_SUB_LIM_0 = 8'h00;
   localparam logic [7:0] LCD_SUB_LIM_1 = 8'h01;
   localparam logic [7:0] LCD_SUB_LIM_2 = 8'h03;

   typedef enum logic [1:0] {
      LCD_DUTY_STATIC,
      LCD_DUTY_HALF,
      LCD_DUTY_THIRD,
      LCD_DUTY_QUARTER
   } lcd_duty_t;

endpackage

// File: hw/lcd_pin_sync.sv
// Three-stage synchroniser with edge report for an asynchronous pin.
// Assumes the pin toggles far slower than clk.
`timescale 1ns/1ps
`default_nettype none
module lcd_pin_sync
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Pin and result
   input wire logic pin_in,
   output logic rise_pulse
);

   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic lvl;
   } lcd_sync_t;

   lcd_sync_t s_q;
   lcd_sync_t s_d;

   always_comb
   begin
      s_d = s_q;
      s_d.s1 = pin_in;
      s_d.s2 = s_q.s1;
      s_d.s3 = s_q.s2;
      // A change counts only once stages two and three agree
      if (s_q.s2 == s_q.s3)
      begin
         s_d.lvl = s_q.s3;
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         s_q <= '0;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   assign rise_pulse = (s_q.s2 == s_q.s3) && s_q.s3 && !s_q.lvl;

endmodule // lcd_pin_sync
`default_nettype wire

// File: tb/lcd_duty_props.sv
// Assertions on the ports of lcd_duty_ctl, bound to every instance.
// Assumes control at 01, port mode at 00, as in lcd_pkg.
`timescale 1ns/1ps
`default_nettype none
module lcd_duty_props
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   // Panel side
   input wire logic subclk_pin,
   input wire logic [1:0] ram_phase,
   input wire logic [39:0] ram_data,
   input wire logic [3:0] common_sel,
   input wire logic [3:0] common_drive_en,
   input wire logic frame_polarity,
   input wire logic [39:0] seg_data,
   input wire logic divider_power_en,
   input wire logic frame_tick
);
   // Shadow registers; q_q counts quiet cycles so latency never matters
   logic [7:0] md_q;
   logic [7:0] ct_q;
   logic [2:0] q_q;
   logic [3:0] drive_exp;
   logic ok;
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         md_q <= 8'h00;
         ct_q <= 8'h80;
         q_q <= 3'h0;
      end
      else
      begin
         if (reg_wr && reg_addr == 8'h00)
            md_q <= reg_wdata;
         if (reg_wr && reg_addr == 8'h01)
            ct_q <= {1'b1, reg_wdata[6:0]};
         q_q <= (reg_wr || q_q == 3'h7) ? (reg_wr ? 3'h0 : q_q) : q_q + 3'h1;
      end
   end
   always_comb
   begin
      case (md_q[7:5])
         3'h0: drive_exp = 4'h1;
         3'h2: drive_exp = 4'h3;
         3'h4: drive_exp = 4'h7;
         default: drive_exp = 4'hF;
      endcase
   end
   assign ok = q_q == 3'h7 && ct_q[5];
   chk_read_ctl:
   assert property ($past(reg_rd && reg_addr == 8'h01)
      |-> reg_rdata == $past(ct_q)) else $error("control readback");
   chk_psw_level:
   assert property (q_q == 3'h7 |-> divider_power_en == ct_q[6])
      else $error("divider enable");
   chk_halt_quiet:
   assert property (q_q == 3'h7 && !ct_q[5] |-> common_drive_en == 4'h0
      && common_sel == 4'h0 && seg_data == 40'h0 && !frame_tick)
      else $error("halted drive");
   chk_drive_en:
   assert property (ok |-> common_drive_en == drive_exp)
      else $error("common drive enables");
   chk_seg_data:
   assert property (ok |-> seg_data == (ct_q[4] ? $past(ram_data) : 40'h0))
      else $error("segment data");
   chk_static_all:
   assert property (ok && md_q[7:5] == 3'h1 |-> common_sel == 4'hF)
      else $error("static expand");
   chk_half_mirror:
   assert property (ok && md_q[7:5] == 3'h3 |-> common_sel[3] == common_sel[2]
      && common_sel[1] == common_sel[0]) else $error("half mirror");
   chk_third_nonsel:
   assert property (ok && md_q[7:5] == 3'h5
      |-> common_drive_en[3] && !common_sel[3]) else $error("third nonsel");
   chk_tick_rate:
   assert property (ok && ct_q[3:0] == 4'h8 |-> frame_tick != $past(frame_tick))
      else $error("tick at clk/2");
   chk_pol_wrap:
   assert property (ok |-> (frame_polarity != $past(frame_polarity))
      == (frame_tick && ram_phase == 2'b00)) else $error("polarity flip");
endmodule // lcd_duty_props
bind lcd_duty_ctl lcd_duty_props u_props (.clk, .rst, .reg_addr, .reg_wdata,
   .reg_wr, .reg_rd, .reg_rdata, .subclk_pin, .ram_phase, .ram_data,
   .common_sel, .common_drive_en, .frame_polarity, .seg_data,
   .divider_power_en, .frame_tick);
`default_nettype wire

// File: tb/lcd_panel_model.sv
// Display RAM stand-in on the panel side of lcd_duty_ctl.
// Assumes ram_phase comes from the clk domain.
`timescale 1ns/1ps
`default_nettype none
module lcd_panel_model
(
   // Clock
   input wire logic clk,
   // Phase and data
   input wire logic [1:0] ram_phase,
   output logic [39:0] ram_data
);
   // A nibble per phase, so a wrong phase shows in the segments
   always_ff @(posedge clk)
   begin
      ram_data <= {10{ram_phase, ~ram_phase}};
   end
endmodule // lcd_panel_model
`default_nettype wire

// File: tb/testbench.sv
// Self-checking bench for lcd_duty_ctl with a display RAM stand-in.
// Assumes lcd_pkg, the design and the bound checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic subclk_pin = 1'b0;
   logic [7:0] reg_rdata;
   logic [1:0] ram_phase;
   logic [39:0] ram_data;
   logic [3:0] common_sel;
   logic [3:0] common_drive_en;
   logic [39:0] seg_data;
   logic divider_power_en;
   logic frame_tick;
   logic frame_polarity;
   logic [7:0] rv;
   int err_total = 0;
   int samples_checked = 0;
   int n;
   // Port mode byte beside the drive enables it should give
   logic [11:0] rows [8] = '{12'h001, 12'h20F, 12'h403, 12'h60F,
      12'h807, 12'hA0F, 12'hC0F, 12'hE0F};
   always #10 clk = ~clk;
   // Subclock runs free at ten system clocks a period
   always #100 subclk_pin = ~subclk_pin;
   lcd_duty_ctl DUT (.clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata, .subclk_pin, .ram_phase, .ram_data, .common_sel,
      .common_drive_en, .frame_polarity, .seg_data, .divider_power_en,
      .frame_tick);
   lcd_panel_model u_panel (.clk, .ram_phase, .ram_data);
   // ****************************************
   // Tasks
   // ****************************************
   task automatic print_verdict();
      if (err_total == 0 && samples_checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic cmp_reg(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         err_total++;
         $display("ERROR %0t reg %h not %h", $time, got, exp);
      end
   endtask
   task automatic cmp_pin(input logic [39:0] got, input logic [39:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         err_total++;
         $display("ERROR %0t pin %h not %h", $time, got, exp);
      end
   endtask
   task automatic idle(input int c);
      repeat (c) @(posedge clk);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 rv = reg_rdata;
   endtask
   // ****************************************
   // Tests
   // ****************************************
   initial
   begin
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      rd(8'h00);
      cmp_reg(rv, 8'h00);
      rd(8'h01);
      cmp_reg(rv, 8'h80);
      wr(8'h01, 8'h7F);
      rd(8'h01);
      cmp_reg(rv, 8'hFF);
      wr(8'h55, 8'hAA);
      rd(8'h55);
      cmp_reg(rv, 8'h00);
      for (int i = 0; i < 8; i++)
      begin
         wr(8'h00, rows[i][11:4]);
         wr(8'h01, 8'h38);
         idle(8);
         cmp_pin(common_drive_en, rows[i][3:0]);
         repeat (4)
         begin
            idle(1);
            if (i == 1) cmp_pin(common_sel, 40'hF);
            if (i == 3) cmp_pin(common_sel == 4'h3 || common_sel == 4'hC, 1);
            if (i == 5) cmp_pin(common_sel[3], 0);
         end
      end
      wr(8'h00, 8'h00);
      idle(8);
      cmp_pin(seg_data, 40'h3333333333);
      rv[0] = frame_polarity;
      idle(2);
      cmp_pin(frame_polarity, !rv[0]);
      wr(8'h01, 8'h68);
      idle(8);
      cmp_pin(seg_data, 40'h0);
      cmp_pin(divider_power_en, 1);
      wr(8'h01, 8'h00);
      idle(8);
      cmp_pin(common_drive_en | seg_data | divider_power_en, 0);
      // Subclock sources first, then clk divided by 2 up to 256
      for (int k = 0; k < 12; k++)
      begin
         wr(8'h01, 8'h20 | 8'(k < 4 ? k : k + 4));
         idle(20);
         n = 0;
         repeat (k < 4 ? 80 : 256)
         begin
            idle(1);
            n += int'(frame_tick);
         end
         cmp_pin(n, k < 4 ? 8 >> (k < 2 ? k : 2) : 128 >> (k - 4));
      end
      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      rd(8'h01);
      cmp_reg(rv, 8'h80);
      print_verdict();
   end
   initial
   begin
      // About 2800 cycles of tests, so this only fires on a hang
      repeat (20000) @(posedge clk);
      err_total++;
      print_verdict();
   end
endmodule // testbench
`default_nettype wire
